/* File: bench/cswb_peer.sv */
// Purpose: Serial peripheral on the far side of the selected pin group.
// Assumes: Clock pin driven by the block or by the bench; edges seen on clk.
// Notes: Sends base xor word index per word, keeps the last bits seen.
`timescale 1ns/1ps
`default_nettype none
module cswb_peer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Serial lines
  input  wire logic       sck,
  input  wire logic       sdo,
  output logic            sdi,
  // Data
  input  wire logic [7:0] base,
  output logic      [7:0] rxByte
);
  logic       prev;
  logic [5:0] cnt;
  logic [7:0] word;

  // Word sent now: one value per word so order shows
  assign word = base ^ {5'h00, cnt[5:3]};

  // data ahead of rising edge, lowest bit first
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev   <= 1'b1;
      cnt    <= 6'h00;
      sdi    <= 1'b1;
      rxByte <= 8'h00;
    end else begin
      prev <= sck;
      if (prev && !sck) begin
        sdi <= word[cnt[2:0]];
        cnt <= cnt + 6'h01;
      end
      if (!prev && sck)
        rxByte <= {sdo, rxByte[7:1]}; // Lowest bit arrives first
    end
  end
endmodule : cswb_peer
`default_nettype wire

/* File: bench/tb_cswb_top.sv */
// Purpose: Self-checking bench for the clocked serial word buffer.
// Assumes: Peer sits on the selected pin group; bench drives the external clock.
// Notes: Periods are clk counts between falling clock pin edges.
`timescale 1ns/1ps
`default_nettype none
module tb_cswb_top
  import cswb_pkg::*;
;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic        lowClkTick, slowMode, grp, pRst_n, sdi, er, prevS;
  logic        sckW, sdoW, burstDoneIrq, extSck;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  sinPin, soutPin, soutOe_n, sckPinOut, sckOe_n;
  logic [7:0]  base, rxByte, rd;
  int          failures, n_tests, nFall, nIrq, cyc, i, j, k;
  int          ft [64];

  cswb_top DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lowClkTick(lowClkTick),
    .slowMode(slowMode), .sinPin(sinPin), .soutPin(soutPin),
    .soutOe_n(soutOe_n), .sckPinIn({sckW, sckW}), .sckPinOut(sckPinOut),
    .sckOe_n(sckOe_n), .burstDoneIrq(burstDoneIrq));

  cswb_peer peer (.clk(clk), .rst_n(pRst_n), .sck(sckW), .sdo(sdoW),
    .sdi(sdi), .base(base), .rxByte(rxByte));

  // Clock wire from block or bench source; unselected group sees inverted data
  assign sckW   = sckOe_n[grp] ? extSck : sckPinOut[grp];
  assign sdoW   = soutOe_n[grp] ? 1'b1 : soutPin[grp];
  assign sinPin = grp ? {sdi, ~sdi} : {~sdi, sdi};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Low clock tick every second cycle
  always @(posedge clk) lowClkTick <= ~lowClkTick;

  // Falling edge times and burst events
  always @(posedge clk) begin
    cyc++;
    if (prevS && !sckW) begin
      ft[nFall % 64] = cyc;
      nFall++;
    end
    prevS = sckW;
    if (burstDoneIrq === 1'b1) nIrq++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic go(input logic [7:0] c1);
    pRst_n <= 1'b0;
    nFall = 0;
    apb(1'b1, IDX_CTL1, c1);
    pRst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(sckW, 1'b1);
  endtask : go

  task automatic waitIrq;
    int n;
    int m;
    n = nIrq;
    for (m = 0; m < 20000 && nIrq == n; m++) @(posedge clk);
    chk(nIrq - n, 1);
  endtask : waitIrq

  // Write control one, then expect an idle status
  task automatic ctlIdle(input logic [7:0] c1);
    apb(1'b1, IDX_CTL1, c1);
    repeat (4) @(posedge clk);
    apb(1'b0, IDX_CTL2, 8'h00);
    chk(rd, 8'h00);
  endtask : ctlIdle

  task automatic endTest(input string s);
    $display("Test %s done, mismatches so far %0d", s, failures);
  endtask : endTest

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    {rstn, psel, penable, pwrite, lowClkTick, slowMode, grp, pRst_n} = 8'h00;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    base = 8'h00;
    extSck = 1'b1;
    prevS = 1'b1;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    pRst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, IDX_CTL2, 8'h00); chk(rd, 8'h00);
    apb(1'b0, IDX_CTL1, 8'h00); chk(rd, 8'h00);
    apb(1'b0, 14'h0FB8, 8'h00); chk(er, 1'b1);
    chk(soutOe_n, 2'b10);
    for (i = 0; i < 8; i++) apb(1'b1, IDX_BUF0 + 14'(i), 8'(8'h11 * i));
    for (i = 0; i < 8; i++) begin
      apb(1'b0, IDX_BUF0 + 14'(i), 8'h00);
      chk(rd, 8'(8'h11 * i));
    end
    endTest("registers");
    // One transmit word for each internal clock select code 0 to 5
    apb(1'b1, IDX_CTL2, 8'h00);
    for (i = 0; i < 6; i++) begin
      slowMode <= (i == 0);
      apb(1'b1, IDX_BUF0, 8'(8'hA5 ^ i));
      go({2'b10, MODE_TX8, 3'(i)});
      waitIrq();
      chk(ft[1] - ft[0], (i == 0) ? 64 : 1 << (9 - i));
      chk(rxByte, 8'(8'hA5 ^ i));
      apb(1'b0, IDX_CTL2, 8'h00); chk(rd, 8'h80);
      k = nFall;
      repeat (300) @(posedge clk);
      chk(nFall, k); chk(sckW, 1'b1);
      ctlIdle({2'b00, MODE_TX8, 3'(i)});
    end
    ctlIdle({2'b10, MODE_TX8, CLK_RSV});
    endTest("clock");
    // Three-word exchange twice; count written once
    apb(1'b1, IDX_CTL2, 8'h02);
    base <= 8'h3C;
    for (j = 0; j < 2; j++) begin
      for (i = 0; i < 3; i++) apb(1'b1, IDX_BUF0 + 14'(i), 8'(8'h11 * (i + 1)));
      go({2'b10, MODE_TXRX8, 3'h5});
      waitIrq();
      chk(nFall, 24);
      chk(ft[8] - ft[0], 128);
      chk(rxByte, 8'h33);
      ctlIdle({2'b00, MODE_TXRX8, 3'h5});
      for (i = 0; i < 3; i++) begin
        apb(1'b0, IDX_BUF0 + 14'(i), 8'h00);
        chk(rd, 8'(8'h3C ^ i));
      end
    end
    apb(1'b1, IDX_CTL2, 8'h09);
    go({2'b10, MODE_TXRX8, 3'h5});
    waitIrq();
    chk(ft[8] - ft[0], 256);
    ctlIdle({2'b00, MODE_TXRX8, 3'h5});
    endTest("exchange");
    // Four-bit receive on pin group one
    apb(1'b1, IDX_MUL, 8'h01);
    grp <= 1'b1;
    base <= 8'hC9;
    repeat (2) @(posedge clk);
    chk(soutOe_n, 2'b01);
    apb(1'b1, IDX_CTL2, 8'h00);
    go({2'b10, MODE_RX4, 3'h5});
    waitIrq();
    ctlIdle({2'b00, MODE_RX4, 3'h5});
    apb(1'b0, IDX_BUF0, 8'h00); chk(rd, 8'h09);
    apb(1'b1, IDX_MUL, 8'h00);
    grp <= 1'b0;
    endTest("group one");
    // External clock from the bench, pin latch high, eight-cycle levels
    apb(1'b1, IDX_BUF0, 8'h5A);
    go({2'b10, MODE_TX8, CLK_EXT});
    chk(sckOe_n, 2'b11);
    k = nIrq;
    for (i = 0; i < 16; i++) begin
      repeat (8) @(posedge clk);
      extSck <= ~extSck;
    end
    repeat (4) @(posedge clk);
    chk(nIrq - k, 1);
    chk(rxByte, 8'h5A);
    apb(1'b0, IDX_CTL2, 8'h00); chk(rd, 8'hC0);
    ctlIdle({2'b01, MODE_TX8, CLK_EXT});
    endTest("external");
    // Abort in mid-word
    go({2'b10, MODE_TX8, 3'h1});
    for (k = 0; k < 5000 && nFall < 3; k++) @(posedge clk);
    k = nIrq;
    ctlIdle({2'b01, MODE_TX8, 3'h1});
    j = nFall;
    repeat (3000) @(posedge clk);
    chk(nIrq, k); chk(nFall, j);
    endTest("abort");
    complete_run();
  end
endmodule : tb_cswb_top
`default_nettype wire

/* File: hdl/cswb_clkgen.sv */
// Purpose: Serial clock source: divided high or low clock, or external pin.
// Assumes: External clock input is synchronous to clk.
// Notes: Stall holds the clock high; events mark pin edges.
`timescale 1ns/1ps
`default_nettype none
module cswb_clkgen
  import cswb_pkg::*;
(
  // Clock and reset
  input wire logic  clk,
  input wire logic  rst_n,
  // Engine bundle
  cswb_link_if.gen  bus
);
  logic [12:0] div_r;
  logic [12:0] halfLim;
  logic [3:0]  logDiv;
  logic        sck_r;
  logic        phase_r;
  logic        extPrev_r;
  logic        useLow;
  logic        intOk;
  logic        baseTick;
  logic        halfTick;
  logic        isExt;

  // R12 divider choice
  always_comb begin
    useLow = bus.lowMode && bus.clkSel == CLK_SLOW;
    if (useLow) begin
      logDiv = LOG_LOW;
    end else if (bus.clkSel == CLK_SLOW) begin
      logDiv = LOG_SLOW;
    end else begin
      logDiv = LOG_BASE - {1'b0, bus.clkSel};
    end
  end
  assign isExt    = bus.clkSel == CLK_EXT;
  assign intOk    = !isExt && bus.clkSel != CLK_RSV;
  assign baseTick = useLow ? bus.lowTick : 1'b1;
  assign halfLim  = (13'd1 << (logDiv - 4'd1)) - 13'd1;
  assign halfTick = intOk && bus.run && baseTick && div_r == halfLim;

  // Half-period counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (!bus.run) begin
      div_r <= '0;
    end else if (baseTick) begin
      div_r <= halfTick ? '0 : div_r + 13'd1;
    end
  end

  // R13 clock idles high, R23 held high while stalled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_r   <= 1'b1;
      phase_r <= 1'b0;
    end else if (!bus.run) begin
      sck_r   <= 1'b1;
      phase_r <= 1'b0;
    end else if (halfTick) begin
      phase_r <= ~phase_r;
      if (!bus.stall || !sck_r) begin
        sck_r <= ~sck_r;
      end
    end
  end

  // External pin history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extPrev_r <= 1'b1;
    end else begin
      extPrev_r <= bus.extSck;
    end
  end

  // Edge events towards the engine
  assign bus.fallEv = isExt ? bus.run && extPrev_r && !bus.extSck
                            : halfTick && sck_r && !bus.stall;
  assign bus.riseEv = isExt ? bus.run && !extPrev_r && bus.extSck
                            : halfTick && !sck_r;
  assign bus.periodTick = halfTick && phase_r;
  assign bus.sckLevel   = sck_r;
endmodule : cswb_clkgen
`default_nettype wire

/* File: hdl/cswb_top.sv */
// Purpose: Clocked serial interface with an eight-word buffer on APB.
// Assumes: Pins synchronous to clk; pready always high.
// Notes: Control one is write-only and reads zero.
`timescale 1ns/1ps
`default_nettype none
module cswb_top
  import cswb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Low clock and operating mode
  input  wire logic        lowClkTick,
  input  wire logic        slowMode,
  // Serial pins, index is pin group
  input  wire logic [1:0]  sinPin,
  output logic      [1:0]  soutPin,
  output logic      [1:0]  soutOe_n,
  input  wire logic [1:0]  sckPinIn,
  output logic      [1:0]  sckPinOut,
  output logic      [1:0]  sckOe_n,
  // Burst event
  output logic             burstDoneIrq
);
  logic           rstMeta_r;
  logic           rstSync_n;
  logic [13:0]    idx;
  logic           setup;
  logic           wrEn;
  logic           rdEn;
  logic           hitBuf;
  logic           hitCtl1;
  logic           hitCtl2;
  logic           hitMul;
  logic           mapped;
  logic [7:0]     rdByte;
  logic [7:0]     statusByte;
  logic           start_r;
  logic [2:0]     mode_r;
  logic [2:0]     clkSel_r;
  logic [1:0]     wait_r;
  logic [2:0]     cnt_r;
  logic           pinSel_r;
  logic           tap_r;
  logic           abortP;
  logic           txMode;
  logic           rxMode;
  logic           fourMode;
  logic           extClk;
  logic           startGo;
  logic           serviced;
  logic           lastBit;
  logic           wordDone;
  logic           burstEnd;
  logic           holdGo;
  logic           loadNow;
  logic [2:0]     nextIdx;
  logic [5:0]     gapLen;
  logic           sinBit;
  logic [7:0]     rxWord;
  cswb_state_type state_r;
  logic [2:0]     wordIdx_r;
  logic [3:0]     bitCnt_r;
  logic [7:0]     shift_r;
  logic           sout_r;
  logic [5:0]     gap_r;
  logic           irq_r;
  logic           loadLate_r;

  cswb_link_if bus ();

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // APB decode, zero wait states
  assign idx     = paddr[15:2];
  assign setup   = psel && !penable;
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && penable && !pwrite;
  assign hitBuf  = idx[13:3] == IDX_BUF0[13:3];
  assign hitCtl1 = idx == IDX_CTL1;
  assign hitCtl2 = idx == IDX_CTL2;
  assign hitMul  = idx == IDX_MUL;
  assign mapped  = hitBuf || hitCtl1 || hitCtl2 || hitMul;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // R8 status byte
  assign statusByte = {state_r != ST_IDLE, state_r == ST_RUN, 6'h00};

  // Read mux
  always_comb begin
    if (hitBuf) begin
      rdByte = bus.apbRdData;
    end else if (hitCtl2) begin
      rdByte = statusByte;
    end else if (hitMul) begin
      rdByte = {6'h00, tap_r, pinSel_r};
    end else begin
      rdByte = 8'h00;
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      prdata <= {24'h00_0000, rdByte};
    end
  end

  // Control one, abort is a self-clearing pulse
  assign abortP = wrEn && hitCtl1 && pwdata[C1_ABORT];
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      start_r  <= CTL_RST[C1_START];
      mode_r   <= CTL_RST[C1_MODE +: 3];
      clkSel_r <= CTL_RST[C1_CLK +: 3];
    end else if (wrEn && hitCtl1) begin
      start_r  <= pwdata[C1_START] && !pwdata[C1_ABORT];
      mode_r   <= pwdata[C1_MODE +: 3];
      clkSel_r <= pwdata[C1_CLK +: 3];
    end
  end

  // R5 control two holds its count until rewritten
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wait_r <= CTL_RST[C2_WAIT +: 2];
      cnt_r  <= CTL_RST[C2_CNT +: 3];
    end else if (wrEn && hitCtl2) begin
      wait_r <= pwdata[C2_WAIT +: 2];
      cnt_r  <= pwdata[C2_CNT +: 3];
    end
  end

  // Multi-function register
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinSel_r <= CTL_RST[MF_PINSEL];
      tap_r    <= CTL_RST[MF_TAP];
    end else if (wrEn && hitMul) begin
      pinSel_r <= pwdata[MF_PINSEL];
      tap_r    <= pwdata[MF_TAP];
    end
  end

  // Mode decode
  assign txMode   = mode_r == MODE_TX8 || mode_r == MODE_TX4 || mode_r == MODE_TXRX8;
  assign rxMode   = mode_r == MODE_TXRX8 || mode_r == MODE_RX8 || mode_r == MODE_RX4;
  assign fourMode = mode_r == MODE_TX4 || mode_r == MODE_RX4;
  assign extClk   = clkSel_r == CLK_EXT;
  assign startGo  = state_r == ST_IDLE && start_r && (txMode || rxMode)
                    && clkSel_r != CLK_RSV;
  // R14 a buffer write (transmit) or read (receive) releases the hold
  assign serviced = rxMode ? rdEn && hitBuf : wrEn && hitBuf;
  assign holdGo   = state_r == ST_HOLD && start_r && serviced;

  // R3 word length, R2 burst length against the count
  assign lastBit  = bitCnt_r == (fourMode ? LAST_BIT4 : LAST_BIT8);
  assign wordDone = state_r == ST_RUN && bus.riseEv && lastBit;
  assign burstEnd = wordDone && wordIdx_r == cnt_r;
  assign nextIdx  = burstEnd ? 3'h0 : wordIdx_r + 3'h1;
  assign loadNow  = startGo || holdGo || wordDone;
  // R1 gap of one, three or seven data times, eight bit periods each
  assign gapLen   = {3'((4'h1 << wait_r) - 4'h1), 3'h0};

  // Transfer sequencer
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_r <= ST_IDLE;
    end else if (abortP) begin
      // R22 abort ends at once
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (startGo) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (wordDone) begin
            // R9 stop request ends after the current word
            if (!start_r) begin
              state_r <= ST_IDLE;
            end else if (burstEnd) begin
              // R14 internal clock waits for the buffer
              state_r <= extClk ? ST_RUN : ST_HOLD;
            end else if (gapLen != 6'h00 && !extClk) begin
              state_r <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          // R23 clock idles high for the frame remainder
          if (bus.periodTick && gap_r == 6'h01) begin
            state_r <= start_r ? ST_RUN : ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (!start_r) begin
            state_r <= ST_IDLE;
          end else if (serviced) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Gap counter in bit periods
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      gap_r <= '0;
    end else if (wordDone) begin
      gap_r <= gapLen;
    end else if (state_r == ST_GAP && bus.periodTick) begin
      gap_r <= gap_r - 6'h01;
    end
  end

  // R4 words walk upward from buffer word zero
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wordIdx_r <= '0;
    end else if (abortP || startGo) begin
      wordIdx_r <= '0;
    end else if (wordDone) begin
      wordIdx_r <= nextIdx;
    end
  end

  // Bit counter, rising pin edges only
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      bitCnt_r <= '0;
    end else if (loadNow || state_r == ST_IDLE) begin
      bitCnt_r <= '0;
    end else if (state_r == ST_RUN && bus.riseEv) begin
      bitCnt_r <= bitCnt_r + 4'h1;
    end
  end

  // R19 rise in, R20 LSB first; next word loads a cycle after the receive write
  assign sinBit = sinPin[pinSel_r];
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      shift_r    <= '0;
      loadLate_r <= 1'b0;
    end else begin
      loadLate_r <= wordDone;
      if (startGo || holdGo || loadLate_r) begin
        shift_r <= (bus.apbWr && bus.apbIdx == bus.engIdx) ? bus.apbData : bus.engRdData;
      end else if (state_r == ST_RUN && bus.riseEv) begin
        shift_r <= {sinBit, shift_r[7:1]};
      end
    end
  end

  // R18 transmit bit changes on the falling edge
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      sout_r <= 1'b1;
    end else if (state_r == ST_RUN && bus.fallEv) begin
      sout_r <= shift_r[0];
    end
  end

  // R3 received nibble lands low, upper half zero
  assign rxWord = fourMode ? {4'h0, sinBit, shift_r[7:5]} : {sinBit, shift_r[7:1]};

  // R21 burst-done request
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= burstEnd && !abortP;
    end
  end
  assign burstDoneIrq = irq_r;

  // Bundle wiring
  assign bus.run     = state_r != ST_IDLE;
  assign bus.stall   = state_r != ST_RUN;
  assign bus.clkSel  = clkSel_r;
  assign bus.lowMode = tap_r || slowMode;
  assign bus.lowTick = lowClkTick;
  assign bus.extSck  = sckPinIn[pinSel_r];
  assign bus.apbWr   = wrEn && hitBuf;
  assign bus.apbIdx  = idx[2:0];
  assign bus.apbData = pwdata[7:0];
  assign bus.engWr   = wordDone && rxMode;
  assign bus.engIdx  = startGo ? 3'h0 : wordIdx_r;
  assign bus.engData = rxWord;

  // R10 pin group routing, R13 internal clock driven out
  for (genvar g = 0; g < 2; g++) begin : g_pins
    assign soutPin[g]   = sout_r;
    assign soutOe_n[g]  = pinSel_r != 1'(g);
    assign sckPinOut[g] = bus.sckLevel;
    assign sckOe_n[g]   = pinSel_r != 1'(g) || extClk;
  end

  cswb_clkgen u_clkgen (
    .clk   (clk),
    .rst_n (rstSync_n),
    .bus   (bus.gen)
  );

  cswb_wordbuf u_wordbuf (
    .clk   (clk),
    .rst_n (rstSync_n),
    .bus   (bus.store)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n);

  a_abort_to_idle: // R22
    assert property (abortP |=> state_r == ST_IDLE && !statusByte[ST_XFER])
    else $error("abort did not end the transfer");
  a_nibble_upper_zero: // R3
    assert property (bus.engWr && fourMode |-> bus.engData[7:4] == 4'h0)
    else $error("received nibble has upper bits set");
  a_count_kept: // R5
    assert property (!(wrEn && hitCtl2) |=> $stable(cnt_r))
    else $error("word count changed without a write");
  a_irq_at_count: // R21
    assert property (burstDoneIrq |-> $past(wordIdx_r) == $past(cnt_r))
    else $error("burst request before the programmed count");
  a_start_word_zero: // R4
    assert property (startGo && !abortP |=> state_r == ST_RUN && wordIdx_r == 3'h0)
    else $error("burst did not start at word zero");
  a_clock_idle_high: // R23
    assert property (!extClk && state_r != ST_RUN && $past(state_r) != ST_RUN
                     |-> bus.sckLevel)
    else $error("serial clock low while not shifting");
  a_tx_on_fall: // R18
    assert property ($changed(sout_r) |-> $past(bus.fallEv))
    else $error("transmit bit changed off the falling edge");
  a_rx_on_rise: // R19
    assert property ($changed(bitCnt_r) && bitCnt_r != 4'h0 |-> $past(bus.riseEv))
    else $error("bit counted off the rising edge");
  a_pin_route: // R10
    assert property (!pinSel_r |-> soutOe_n == 2'b10)
    else $error("wrong pin group enabled");
endmodule : cswb_top
`default_nettype wire

/* File: hdl/cswb_wordbuf.sv */
// Purpose: Eight-word data buffer shared by software and the shift engine.
// Assumes: Engine write wins over a software write to the same word.
// Notes: Reads are combinational.
`timescale 1ns/1ps
`default_nettype none
module cswb_wordbuf
  import cswb_pkg::*;
(
  // Clock and reset
  input wire logic    clk,
  input wire logic    rst_n,
  // Access bundle
  cswb_link_if.store  bus
);
  logic [7:0] mem [BUF_WORDS];

  // One storage word per entry
  for (genvar i = 0; i < BUF_WORDS; i++) begin : g_word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem[i] <= 8'h00;
      end else if (bus.engWr && bus.engIdx == 3'(i)) begin
        mem[i] <= bus.engData;
      end else if (bus.apbWr && bus.apbIdx == 3'(i)) begin
        mem[i] <= bus.apbData;
      end
    end
  end

  // Read ports
  assign bus.apbRdData = mem[bus.apbIdx];
  assign bus.engRdData = mem[bus.engIdx];
endmodule : cswb_wordbuf
`default_nettype wire

/* File: include/cswb_link_if.sv */
// Purpose: Bundles between the engine, its clock generator and word buffer.
// Assumes: One clock domain.
// Notes: Events are one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
interface cswb_link_if;
  logic       run;
  logic       stall;
  logic [2:0] clkSel;
  logic       lowMode;
  logic       lowTick;
  logic       extSck;
  logic       fallEv;
  logic       riseEv;
  logic       periodTick;
  logic       sckLevel;
  logic       apbWr;
  logic [2:0] apbIdx;
  logic [7:0] apbData;
  logic [7:0] apbRdData;
  logic       engWr;
  logic [2:0] engIdx;
  logic [7:0] engData;
  logic [7:0] engRdData;
  modport gen (input run, stall, clkSel, lowMode, lowTick, extSck,
               output fallEv, riseEv, periodTick, sckLevel);
  modport store (input apbWr, apbIdx, apbData, engWr, engIdx, engData,
                 output apbRdData, engRdData);
  modport eng (output run, stall, clkSel, lowMode, lowTick, extSck,
               apbWr, apbIdx, apbData, engWr, engIdx, engData,
               input fallEv, riseEv, periodTick, sckLevel, apbRdData, engRdData);
endinterface : cswb_link_if
`default_nettype wire

/* File: include/cswb_pkg.sv */
// Purpose: Shared constants and types for the clocked serial word buffer.
// Assumes: APB byte address = register index * 4; 8-bit data in low lane.
// Notes:
// Behaviour
// R1: Wait field stays 00 outside 8-bit transmit/receive; 01/10/11 stretch frame 2/4/8x.
// R2: Word count 000..111 selects one to eight words from buffer word zero.
// R3: 4-bit transfers use the low nibble; received high nibble is zero.
// R4: Transmit from lowest buffer word; store received words in ascending order.
// R5: The programmed word count is kept after every burst.
// R6: Software writes control two only while transfer_active reads zero.
// R7: Control two is write-only; no read-modify-write updates.
// R8: Status bit 7 shows transfer active, bit 6 shows shift active.
// R9: After start clears, transfer_active drops when the transfer ends; abort drops it.
// R10: Pin-set select 0 routes pins to group zero, 1 to group one.
// R11: Software keeps pin-set select fixed while running and sets it first.
// R12: Clock select picks high clock dividers, low clock divider, reserved or external.
// R13: Internal clock is driven on the clock pin, high when transfer starts.
// R14: Internal clock halts after a burst until software services the buffer.
// R15: External clock pulses last at least four machine cycles.
// R16: Software sets the clock pin latch high for external clock input.
// R17: External clock rate stays below about 488.3 kbit/s at 16 MHz.
// R18: Transmit data shifts out on the falling clock pin edge.
// R19: Receive data shifts in on the rising clock pin edge.
// R20: Each word travels least significant bit first.
// R21: A burst-done request is raised when the programmed words are moved.
// R22: Abort ends the transfer at once and clears transfer_active.
// R23: During the inter-word wait the clock idles high.
package cswb_pkg;
  // Register indices (byte address is index times four)
  localparam logic [13:0] IDX_BUF0 = 14'h0FA0;
  localparam logic [13:0] IDX_CTL1 = 14'h0FA8;
  localparam logic [13:0] IDX_CTL2 = 14'h0FA9;
  localparam logic [13:0] IDX_MUL  = 14'h0FB0;
  localparam logic [7:0]  CTL_RST  = 8'h00;
  // Field positions
  localparam int C1_START  = 7;
  localparam int C1_ABORT  = 6;
  localparam int C1_MODE   = 3;
  localparam int C1_CLK    = 0;
  localparam int C2_WAIT   = 3;
  localparam int C2_CNT    = 0;
  localparam int ST_XFER   = 7;
  localparam int ST_SHIFT  = 6;
  localparam int MF_PINSEL = 0;
  localparam int MF_TAP    = 1;
  // Transfer modes
  localparam logic [2:0] MODE_TX8   = 3'h0;
  localparam logic [2:0] MODE_TX4   = 3'h2;
  localparam logic [2:0] MODE_TXRX8 = 3'h4;
  localparam logic [2:0] MODE_RX8   = 3'h5;
  localparam logic [2:0] MODE_RX4   = 3'h6;
  // Clock select codes and divider exponents
  localparam logic [2:0] CLK_SLOW = 3'h0;
  localparam logic [2:0] CLK_RSV  = 3'h6;
  localparam logic [2:0] CLK_EXT  = 3'h7;
  localparam logic [3:0] LOG_LOW  = 4'h5;
  localparam logic [3:0] LOG_SLOW = 4'hD;
  localparam logic [3:0] LOG_BASE = 4'h9;
  // Word geometry
  localparam int         BUF_WORDS = 8;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT4 = 4'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_GAP, ST_HOLD} cswb_state_type;
endpackage : cswb_pkg
